// File: qdic_input_ctrl.sv
/*
 Quadrature decoder input control: mode and gate selection, input
 filter, polarity and swap, index capture, position counter and the
 compare output pin. Assumes encoder inputs synchronous to core_clk
 and a register port with read data one cycle after the read strobe.
*/
// Notes on behaviour
// - Gate enable set: external gate controls counting; clear: gate ignored.
// - Mode 11 timer+gate, 10 ext clock+gate, 01 ext clock+dir, 00 quadrature.
// - Capture enable set: position captured on index rising edge; else none.
// - Filter enable filters all four inputs; clear bypasses them.
// - Filter divide code n selects sample rate 1:2**n, 1:1 to 1:128.
// - Output code 11: pin high when count below lower or above upper.
// - Output code 10: pin high when count below lower.
// - Output code 01: pin high when count at or above upper.
// - Output code 00: comparison never drives the pin.
// - Swap set exchanges phase A and B before decoding.
// - Reference polarity set inverts the reference input.
module qdic_input_ctrl import qdic_pkg::*; #(
   parameter int CNT_W = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [DATA_W-1:0] regRdData,
   input wire logic phase_a_input,
   input wire logic phase_b_input,
   input wire logic marker_input,
   input wire logic reference_input,
   input wire logic gateInput,
   output logic compare_output_pin,
   output logic compareOutputEn,
   output logic captureEvent
);
   logic [DATA_W-1:0] decCtrl;
   logic [DATA_W-1:0] next_decCtrl;
   logic [11:0] ioCtrl;
   logic [11:0] next_ioCtrl;
   logic [CNT_W-1:0] position_counter;
   logic [CNT_W-1:0] next_position_counter;
   logic [CNT_W-1:0] lower_compare_value;
   logic [CNT_W-1:0] next_lower_compare_value;
   logic [CNT_W-1:0] upper_compare_value;
   logic [CNT_W-1:0] next_upper_compare_value;
   logic [CNT_W-1:0] capturePos;
   logic [CNT_W-1:0] next_capturePos;
   logic [DATA_W-1:0] next_regRdData;
   logic next_compare_output_pin;
   logic next_captureEvent;
   logic [3:0] rawIn;
   logic [3:0] fltIn;
   logic [3:0] selIn;
   logic [3:0] polIn;
   logic [3:0] prevIn;
   logic [3:0] next_prevIn;
   logic fltTick;
   logic external_gate_enable;
   logic [1:0] counter_mode_select;
   logic marker_capture_enable;
   logic input_filter_enable;
   logic [2:0] filter_clock_divide;
   logic [1:0] compare_output_function;
   logic swap_phase_inputs;
   logic phaseA;
   logic phaseB;
   logic markerIn;
   logic gateOpen;
   logic countUp;
   logic countDn;
   qdic_qstate_t quadState;
   qdic_qstate_t next_quadState;
   qdic_qstate_t seenState;

   assign external_gate_enable = decCtrl[GATE_EN_BIT];
   assign counter_mode_select = decCtrl[MODE_LSB +: 2];
   assign marker_capture_enable = ioCtrl[CAP_EN_BIT - CTRL_LSB];
   assign input_filter_enable = ioCtrl[FLT_EN_BIT - CTRL_LSB];
   assign filter_clock_divide = ioCtrl[FDIV_LSB - CTRL_LSB +: 3];
   assign compare_output_function = ioCtrl[OUTFN_LSB - CTRL_LSB +: 2];
   assign swap_phase_inputs = ioCtrl[SWAP_BIT - CTRL_LSB];

   // Bit order: reference, marker, phase B, phase A as in the status nibble
   assign rawIn = {reference_input, marker_input, phase_b_input, phase_a_input};

   qdic_clk_div u_div (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .sel(filter_clock_divide),
      .tick(fltTick)
   );

   // Filter runs even while bypassed, so its levels are settled when enabled
   qdic_filter #(.N(4)) u_flt (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tick(fltTick),
      .din(rawIn),
      .dout(fltIn)
   );

   always_comb begin
      selIn = input_filter_enable ? fltIn : rawIn;
      // Polarity bits sit in the same order as the inputs
      polIn = selIn ^ ioCtrl[3:0];
      phaseA = swap_phase_inputs ? polIn[1] : polIn[0];
      phaseB = swap_phase_inputs ? polIn[0] : polIn[1];
      markerIn = polIn[2];
   end

   // Quadrature state from the conditioned phases
   always_comb begin
      case ({phaseB, phaseA})
         2'b00: seenState = QS_00;
         2'b01: seenState = QS_01;
         2'b11: seenState = QS_11;
         default: seenState = QS_10;
      endcase
   end

   always_comb begin
      gateOpen = 1'b1;
      if (external_gate_enable) begin
         gateOpen = gateInput;
      end
      countUp = 1'b0;
      countDn = 1'b0;
      next_quadState = seenState;
      case (counter_mode_select)
         MODE_QUAD: begin
            case (quadState)
               QS_00: begin
                  countUp = (seenState == QS_01);
                  countDn = (seenState == QS_10);
               end
               QS_01: begin
                  countUp = (seenState == QS_11);
                  countDn = (seenState == QS_00);
               end
               QS_11: begin
                  countUp = (seenState == QS_10);
                  countDn = (seenState == QS_01);
               end
               default: begin
                  countUp = (seenState == QS_00);
                  countDn = (seenState == QS_11);
               end
            endcase
         end
         MODE_EXT_UPDN: begin
            // Phase A rising edges are the clock, phase B the direction
            countUp = phaseA & ~prevIn[0] & phaseB;
            countDn = phaseA & ~prevIn[0] & ~phaseB;
         end
         MODE_EXT_GATE: begin
            // Only rising edges of phase A count, always upwards
            countUp = phaseA & ~prevIn[0];
         end
         default: begin
            countUp = 1'b1;
         end
      endcase
      if (!gateOpen) begin
         countUp = 1'b0;
         countDn = 1'b0;
      end
      next_prevIn = {polIn[3], markerIn, phaseB, phaseA};
      // A software write to the counter wins over a count in the same cycle
      next_position_counter = position_counter;
      if (regWrEn && regAddr == REG_POS_CNT) begin
         next_position_counter = regWrData[CNT_W-1:0];
      end else if (countUp) begin
         next_position_counter = position_counter + CNT_W'(1);
      end else if (countDn) begin
         next_position_counter = position_counter - CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         position_counter <= '0;
         prevIn <= 4'h0;
         quadState <= QS_00;
      end else begin
         position_counter <= next_position_counter;
         prevIn <= next_prevIn;
         quadState <= next_quadState;
      end
   end

   // Captures the count as it stood before this edge, so a step landing in
   // the same cycle as the marker edge is not part of the captured value
   always_comb begin
      next_captureEvent = marker_capture_enable & markerIn & ~prevIn[2];
      next_capturePos = capturePos;
      if (next_captureEvent) begin
         next_capturePos = position_counter;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         capturePos <= '0;
         captureEvent <= 1'b0;
      end else begin
         capturePos <= next_capturePos;
         captureEvent <= next_captureEvent;
      end
   end

   // Unsigned compare; the pin lags the counter by one cycle
   always_comb begin
      case (compare_output_function)
         OUT_OUTSIDE: begin
            next_compare_output_pin = (position_counter < lower_compare_value)
               || (position_counter > upper_compare_value);
         end
         OUT_BELOW_LOWER: begin
            next_compare_output_pin = (position_counter < lower_compare_value);
         end
         OUT_GE_UPPER: begin
            next_compare_output_pin = (position_counter >= upper_compare_value);
         end
         default: begin
            next_compare_output_pin = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         compare_output_pin <= 1'b0;
      end else begin
         compare_output_pin <= next_compare_output_pin;
      end
   end

   // Pin is released while the output function is off
   assign compareOutputEn = (compare_output_function != OUT_OFF);

   // Register writes; the counter itself is written in the counter group
   always_comb begin
      next_decCtrl = decCtrl;
      next_ioCtrl = ioCtrl;
      next_lower_compare_value = lower_compare_value;
      next_upper_compare_value = upper_compare_value;
      if (regWrEn) begin
         if (regAddr == REG_DEC_CTRL) begin
            next_decCtrl = regWrData & DEC_CTRL_MASK;
         end else if (regAddr == REG_IO_CTRL) begin
            // Status nibble is read-only, so only the upper twelve bits are kept
            next_ioCtrl = regWrData[15:CTRL_LSB];
         end else if (regAddr == REG_LOWER_CMP) begin
            next_lower_compare_value = regWrData[CNT_W-1:0];
         end else if (regAddr == REG_UPPER_CMP) begin
            next_upper_compare_value = regWrData[CNT_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         decCtrl <= DEC_CTRL_RST;
         ioCtrl <= IO_CTRL_RST;
         lower_compare_value <= '0;
         upper_compare_value <= '0;
      end else begin
         decCtrl <= next_decCtrl;
         ioCtrl <= next_ioCtrl;
         lower_compare_value <= next_lower_compare_value;
         upper_compare_value <= next_upper_compare_value;
      end
   end

   // Reads answer one cycle later and return zero when idle or unmapped
   always_comb begin
      next_regRdData = '0;
      if (regRdEn) begin
         if (regAddr == REG_DEC_CTRL) begin
            next_regRdData = decCtrl;
         end else if (regAddr == REG_IO_CTRL) begin
            // Status shows levels after filter and polarity, before the swap
            next_regRdData = {ioCtrl, polIn};
         end else if (regAddr == REG_POS_CNT) begin
            next_regRdData = position_counter;
         end else if (regAddr == REG_LOWER_CMP) begin
            next_regRdData = lower_compare_value;
         end else if (regAddr == REG_UPPER_CMP) begin
            next_regRdData = upper_compare_value;
         end else if (regAddr == REG_CAPTURE) begin
            next_regRdData = capturePos;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= '0;
      end else begin
         regRdData <= next_regRdData;
      end
   end
endmodule // qdic_input_ctrl

// File: qdic_pkg.sv
/*
 Package for the quadrature decoder input control block: register
 indices, field positions, reset values and mode encodings.
 Assumes a 16-bit register port addressed by register index.
*/
package qdic_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   // Register indices on the plain register port
   localparam logic [3:0] REG_DEC_CTRL = 4'h0;
   localparam logic [3:0] REG_IO_CTRL = 4'h1;
   localparam logic [3:0] REG_POS_CNT = 4'h2;
   localparam logic [3:0] REG_LOWER_CMP = 4'h3;
   localparam logic [3:0] REG_UPPER_CMP = 4'h4;
   localparam logic [3:0] REG_CAPTURE = 4'h5;
   // Decoder control fields
   localparam int GATE_EN_BIT = 2;
   localparam int MODE_LSB = 0;
   // I/O control fields
   localparam int CAP_EN_BIT = 15;
   localparam int FLT_EN_BIT = 14;
   localparam int FDIV_LSB = 11;
   localparam int OUTFN_LSB = 9;
   localparam int SWAP_BIT = 8;
   localparam int REF_POL_BIT = 7;
   localparam int MRK_POL_BIT = 6;
   localparam int PHB_POL_BIT = 5;
   localparam int PHA_POL_BIT = 4;
   localparam int CTRL_LSB = 4;
   localparam logic [15:0] DEC_CTRL_RST = 16'h0000;
   localparam logic [11:0] IO_CTRL_RST = 12'h000;
   localparam logic [15:0] DEC_CTRL_MASK = 16'h0007;
   // Filter needs the same sampled level this many times in a row
   localparam int FLT_SAMPLES = 3;
   typedef enum logic [1:0] {
      MODE_QUAD = 2'b00, MODE_EXT_UPDN = 2'b01, MODE_EXT_GATE = 2'b10, MODE_TMR_GATE = 2'b11
   } qdic_mode_t;
   typedef enum logic [1:0] {
      OUT_OFF = 2'b00, OUT_GE_UPPER = 2'b01, OUT_BELOW_LOWER = 2'b10, OUT_OUTSIDE = 2'b11
   } qdic_outfn_t;
   typedef enum logic [3:0] {
      QS_00 = 4'b0001, QS_01 = 4'b0010, QS_11 = 4'b0100, QS_10 = 4'b1000
   } qdic_qstate_t;
endpackage

// File: qdic_clk_div.sv
/*
 Filter sample enable divider: one-cycle pulse every 2**sel clocks.
 Assumes one clock; sel may change at any time.
*/
module qdic_clk_div import qdic_pkg::*; (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] sel,
   output logic tick
);
   logic [6:0] cnt;
   logic [6:0] next_cnt;
   logic [6:0] lim;
   always_comb begin
      lim = 7'((8'h01 << sel) - 8'h01);
      next_cnt = (cnt >= lim) ? 7'h00 : cnt + 7'h01;
      tick = (cnt >= lim);
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) cnt <= 7'h00;
      else cnt <= next_cnt;
   end
endmodule // qdic_clk_div

// File: qdic_filter.sv
/*
 Digital input filter for the four encoder inputs: a level is accepted
 after FLT_SAMPLES equal samples taken on the sample enable.
 Assumes inputs synchronous to core_clk.
*/
module qdic_filter import qdic_pkg::*; #(
   parameter int N = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic [N-1:0] din,
   output logic [N-1:0] dout
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_ch
         logic [1:0] cnt;
         logic [1:0] next_cnt;
         logic lvl;
         logic next_lvl;
         always_comb begin
            next_cnt = cnt;
            next_lvl = lvl;
            if (tick) begin
               if (din[i] == lvl) next_cnt = 2'h0;
               else if (cnt == 2'(FLT_SAMPLES - 1)) begin
                  next_cnt = 2'h0;
                  next_lvl = din[i];
               end else next_cnt = cnt + 2'h1;
            end
         end
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               cnt <= 2'h0;
               lvl <= 1'b0;
            end else begin
               cnt <= next_cnt;
               lvl <= next_lvl;
            end
         end
         assign dout[i] = lvl;
      end
   endgenerate
endmodule // qdic_filter

// File: qdic_encoder_model.sv
/* Encoder model: quadrature phases, marker and reference levels.
 Assumes step and mark requests are one-cycle pulses on core_clk. */
module qdic_encoder_model (
   input wire logic core_clk,
   input wire logic step,
   input wire logic mark,
   input wire logic refLevel,
   output logic phaseA,
   output logic phaseB,
   output logic marker,
   output logic reference
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] pos = 2'h0;
   logic markQ = 1'b0;
   always @(posedge core_clk) begin
      if (step) pos <= pos + 2'h1;
      markQ <= mark;
   end
   // Gray order: one phase moves per step, A leads B when counting up
   assign phaseA = pos[1] ^ pos[0];
   assign phaseB = pos[1];
   assign marker = markQ;
   assign reference = refLevel;
endmodule // qdic_encoder_model

// File: qdic_input_ctrl_asserts.sv
/* Checker for the input control block: read-back, output enable, capture.
 Assumes it is bound to the top module's ports. */
module qdic_input_ctrl_asserts import qdic_pkg::*; #(
   parameter int CNT_W = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic compareOutputEn,
   input wire logic captureEvent
);
   logic [15:0] decSh, ioSh, loSh, hiSh;
   logic [15:0] next_decSh, next_ioSh, next_loSh, next_hiSh;
   always_comb begin
      next_decSh = decSh;
      next_ioSh = ioSh;
      next_loSh = loSh;
      next_hiSh = hiSh;
      if (regWrEn) begin
         case (regAddr)
            REG_DEC_CTRL: next_decSh = regWrData & DEC_CTRL_MASK;
            REG_IO_CTRL: next_ioSh = {regWrData[15:4], 4'h0};
            REG_LOWER_CMP: next_loSh = regWrData;
            REG_UPPER_CMP: next_hiSh = regWrData;
            default: ;
         endcase
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         decSh <= DEC_CTRL_RST;
         ioSh <= 16'h0000;
         loSh <= 16'h0000;
         hiSh <= 16'h0000;
      end else begin
         decSh <= next_decSh;
         ioSh <= next_ioSh;
         loSh <= next_loSh;
         hiSh <= next_hiSh;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   dec_rdback_a: assert property (regRdEn && regAddr == REG_DEC_CTRL |=> regRdData == decSh)
      else $error("decoder control read-back wrong");
   io_rdback_a: assert property (regRdEn && regAddr == REG_IO_CTRL |=> regRdData[15:4] == ioSh[15:4])
      else $error("io control read-back wrong");
   lower_rdback_a: assert property (regRdEn && regAddr == REG_LOWER_CMP |=> regRdData == loSh)
      else $error("lower compare read-back wrong");
   upper_rdback_a: assert property (regRdEn && regAddr == REG_UPPER_CMP |=> regRdData == hiSh)
      else $error("upper compare read-back wrong");
   unmapped_rd_a: assert property (regRdEn && regAddr > REG_CAPTURE |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   idle_rd_a: assert property (!regRdEn |=> regRdData == 16'h0000)
      else $error("read data outside read cycle");
   out_en_a: assert property (compareOutputEn == (ioSh[OUTFN_LSB +: 2] != 2'b00))
      else $error("compare enable disagrees with function");
   cap_gate_a: assert property (captureEvent |-> $past(ioSh[CAP_EN_BIT]))
      else $error("capture while disabled");
   cap_pulse_a: assert property (captureEvent |=> !captureEvent)
      else $error("capture pulse too long");
   cover property (captureEvent);
   cover property (compareOutputEn && ioSh[OUTFN_LSB +: 2] == 2'b11);
   cover property (regRdEn && regAddr > REG_CAPTURE);
endmodule // qdic_input_ctrl_asserts

bind qdic_input_ctrl qdic_input_ctrl_asserts #(.CNT_W(CNT_W)) u_chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
   .regRdEn(regRdEn), .regRdData(regRdData), .compareOutputEn(compareOutputEn),
   .captureEvent(captureEvent));

// File: tb.sv
/* Self-checking bench for the input control block with an encoder model.
 Assumes read data stand in the cycle after the read strobe. */
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module tb import qdic_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, sys_rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000, regRdData, rdv;
   logic step = 1'b0, mark = 1'b0, refLevel = 1'b0, gateInput = 1'b0;
   logic phA, phB, mrk, rfc, pin, outEn, capEv;
   int bad_count = 0, cmp_count = 0;
   always #10 core_clk = ~core_clk;
   qdic_encoder_model enc (.core_clk(core_clk), .step(step), .mark(mark), .refLevel(refLevel),
      .phaseA(phA), .phaseB(phB), .marker(mrk), .reference(rfc));
   qdic_input_ctrl #(.CNT_W(16)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .phase_a_input(phA), .phase_b_input(phB), .marker_input(mrk), .reference_input(rfc),
      .gateInput(gateInput), .compare_output_pin(pin), .compareOutputEn(outEn),
      .captureEvent(capEv));
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge core_clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      @(negedge core_clk);
      rdv = regRdData;
   endtask
   task automatic steps(input int n);
      repeat (n) begin
         @(posedge core_clk);
         step <= 1'b1;
         @(posedge core_clk);
         step <= 1'b0;
         idle(4);
      end
   endtask
   // Two reads two cycles apart, so a free-running count must advance by 2
   task automatic delta(input logic [15:0] e);
      logic [15:0] p;
      idle(4);
      rd(REG_POS_CNT);
      p = rdv;
      rd(REG_POS_CNT);
      `CHK(16'(rdv - p), e)
   endtask
   task automatic mark_watch(input logic e);
      logic s;
      s = 1'b0;
      @(posedge core_clk);
      mark <= 1'b1;
      @(posedge core_clk);
      mark <= 1'b0;
      repeat (20) begin
         @(negedge core_clk);
         if (capEv === 1'b1) s = 1'b1;
      end
      `CHK(s, e)
   endtask
   task automatic test_done;
      $display("Counts: %0d compared, %0d mismatched", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      rd(REG_DEC_CTRL);
      `CHK(rdv, 16'h0000)
      rd(REG_IO_CTRL);
      `CHK(rdv[15:4], 12'h000)
      rd(4'hf);
      `CHK(rdv, 16'h0000)
      wr(REG_DEC_CTRL, 16'hffff);
      rd(REG_DEC_CTRL);
      `CHK(rdv, 16'h0007)
      wr(REG_DEC_CTRL, 16'h0000);
      $display("Test reset done");
   endtask
   task automatic t_compare;
      logic [15:0] cnt [4] = '{16'd50, 16'd100, 16'd200, 16'd250};
      logic e;
      wr(REG_LOWER_CMP, 16'd100);
      wr(REG_UPPER_CMP, 16'd200);
      for (int f = 0; f < 4; f++) begin
         for (int i = 0; i < 4; i++) begin
            wr(REG_IO_CTRL, 16'(f) << OUTFN_LSB);
            wr(REG_POS_CNT, cnt[i]);
            repeat (3) @(negedge core_clk);
            e = (f[1] && cnt[i] < 16'd100) || (f == 1 && cnt[i] >= 16'd200);
            e = e || (f == 3 && cnt[i] > 16'd200);
            `CHK(outEn, f != 0)
            `CHK(pin, e)
         end
      end
      $display("Test compare done");
   endtask
   task automatic t_quad;
      wr(REG_IO_CTRL, 16'h0000);
      wr(REG_POS_CNT, 16'h0000);
      steps(4);
      rd(REG_POS_CNT);
      `CHK(rdv, 16'h0004)
      wr(REG_IO_CTRL, 16'h0100);
      steps(2);
      rd(REG_POS_CNT);
      `CHK(rdv, 16'h0002)
      $display("Test quadrature done");
   endtask
   task automatic t_modes;
      wr(REG_IO_CTRL, 16'h0000);
      wr(REG_DEC_CTRL, 16'h0007);
      delta(16'h0000);
      wr(REG_DEC_CTRL, 16'h0003);
      delta(16'h0002);
      wr(REG_DEC_CTRL, 16'h0007);
      gateInput <= 1'b1;
      delta(16'h0002);
      wr(REG_DEC_CTRL, 16'h0006);
      wr(REG_POS_CNT, 16'h0000);
      steps(4);
      rd(REG_POS_CNT);
      `CHK(rdv, 16'h0001)
      wr(REG_DEC_CTRL, 16'h0001);
      wr(REG_POS_CNT, 16'h0000);
      steps(4);
      rd(REG_POS_CNT);
      `CHK(rdv, 16'hffff)
      wr(REG_DEC_CTRL, 16'h0000);
      $display("Test modes done");
   endtask
   task automatic t_levels;
      wr(REG_IO_CTRL, 16'h0000);
      idle(4);
      rd(REG_IO_CTRL);
      `CHK(rdv[3:0], 4'h3)
      wr(REG_IO_CTRL, 16'h00f0);
      idle(4);
      rd(REG_IO_CTRL);
      `CHK(rdv, 16'h00fc)
      idle(1);
      refLevel <= 1'b1;
      idle(4);
      rd(REG_IO_CTRL);
      `CHK(rdv[3:0], 4'h4)
      idle(1);
      refLevel <= 1'b0;
      $display("Test levels done");
   endtask
   task automatic t_filter;
      logic [2:0] cs [3] = '{3'h0, 3'h3, 3'h7};
      for (int k = 0; k < 3; k++) begin
         wr(REG_IO_CTRL, 16'h4000 | (16'(cs[k]) << FDIV_LSB));
         idle(1000);
         steps(2);
         rd(REG_IO_CTRL);
         if (k == 2) `CHK(rdv[0], 1'b1)
         idle(8 << cs[k]);
         rd(REG_IO_CTRL);
         `CHK(rdv[0], k == 1)
      end
      wr(REG_IO_CTRL, 16'h0000);
      $display("Test filter done");
   endtask
   task automatic t_capture;
      wr(REG_IO_CTRL, 16'h8000);
      wr(REG_POS_CNT, 16'h1234);
      mark_watch(1'b1);
      rd(REG_CAPTURE);
      `CHK(rdv, 16'h1234)
      wr(REG_IO_CTRL, 16'h0000);
      mark_watch(1'b0);
      $display("Test capture done");
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset;
      t_compare;
      t_quad;
      t_modes;
      t_levels;
      t_filter;
      t_capture;
      test_done;
   end
endmodule // tb
